// File: logic/bfb_map.svh
// Purpose: Constants for the Boolean function blocks
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef BFB_MAP_SVH
`define BFB_MAP_SVH
`define BFB_NUM_INPUTS 4
`define BFB_LEGACY_INPUTS 3
`define BFB_CYCLE_NS 1000
`define BFB_CLK_NS 50
`define BFB_CYCLE_DIV (`BFB_CYCLE_NS / `BFB_CLK_NS)
`define BFB_UNUSED_LEVEL 1'b1
`define BFB_OUT_RESET 1'b0
`define BFB_NAND_RESET 1'b1
`endif

// File: logic/bfb_pkg.sv
// Purpose: Types for the Boolean function blocks
// Assumes: Constants come from bfb_map.svh
// Notes: No imports; use bfb_pkg::name
`default_nettype none
`include "bfb_map.svh"
package bfb_pkg;
    typedef logic [`BFB_NUM_INPUTS-1:0] bfb_vec_t;
    typedef logic [7:0] bfb_cnt_t;
endpackage
`default_nettype wire

// File: logic/bfb_cond.sv
// Purpose: Per-input conditioning: unused default and inversion
// Assumes: Inputs already synchronised
// Notes: Pure combinational
`timescale 1ns/100ps
`default_nettype none
`include "bfb_map.svh"
module bfb_cond (
    input wire bfb_pkg::bfb_vec_t raw_i,
    input wire bfb_pkg::bfb_vec_t used_i,
    input wire bfb_pkg::bfb_vec_t inv_i,
    input wire logic legacy_i,
    output var bfb_pkg::bfb_vec_t cond_o
);
    // Unused forced high, then optional inversion on used inputs
    always_comb begin
        cond_o = '1;
        for (int k = 0; k < `BFB_NUM_INPUTS; k++) begin
            if (!used_i[k] || (legacy_i && k >= `BFB_LEGACY_INPUTS)) begin
                cond_o[k] = `BFB_UNUSED_LEVEL;
            end else begin
                cond_o[k] = raw_i[k] ^ inv_i[k];
            end
        end
    end
endmodule
`default_nettype wire

// File: logic/bfb_top.sv
// Purpose: AND, edge AND, NAND and edge NAND blocks, evaluated per program cycle
// Assumes: All pin inputs asynchronous; configuration masks change rarely
// Notes: All outputs registered
`timescale 1ns/100ps
`default_nettype none
`include "bfb_map.svh"
module bfb_top (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire bfb_pkg::bfb_vec_t IN_I,
    input wire bfb_pkg::bfb_vec_t USED_I,
    input wire bfb_pkg::bfb_vec_t INVERT_I,
    input wire logic LEGACY_I,
    output logic AND_O,
    output logic EDGE_AND_O,
    output logic NAND_O,
    output logic EDGE_NAND_O,
    output logic CYCLE_O
);
    // Timing of one evaluation, counted in reference clocks
    // Clock 0: a pin input changes
    // Clock 1: the first synchroniser stage takes it
    // Clock 2: the second stage takes it; conditioning sees it
    // Next enable: all four results are worked out together
    // One clock later: results appear and stand a whole program cycle
    // Pin to result latency is three to twenty-two clocks
    // Masks are synchronised like the data
    // So a mask and a data change in one clock reach one evaluation
    // And a metastable mask bit never reaches the reduction
    // Bits of one vector may straddle a sampling edge
    // Such a bit is late by one program cycle at most
    // A pin pulse shorter than a program cycle may be missed
    // History moves only on the enable
    // So glitches between evaluations never cause an edge pulse

    // Edge AND example, one line per evaluation
    // Inputs 1,1,0,1: AND 0, edge AND 0
    // Inputs 1,1,1,1: AND 1, edge AND 1
    // Inputs 1,1,1,1: AND 1, edge AND 0
    // Inputs 1,0,1,1: AND 0, edge AND 0
    // Inputs 1,1,1,1: AND 1, edge AND 1
    // Edge NAND mirrors this on the NAND result
    // Inputs 1,1,1,1: NAND 0, edge NAND 0
    // Inputs 0,1,1,1: NAND 1, edge NAND 1
    // Inputs 0,1,1,1: NAND 1, edge NAND 0
    // Conditioning per input, highest priority first
    // Unconnected: seen as 1
    // Three-input mode, fourth input: seen as 1
    // Inverted: seen as the opposite of the pin
    // Otherwise: seen as the pin
    // After reset the history reads settled
    // So the first evaluation pulses neither edge output

    // Program cycle length in reference clocks and the last divider count
    localparam int unsigned cycle_clocks = `BFB_CYCLE_DIV;
    localparam bfb_pkg::bfb_cnt_t div_last = bfb_pkg::bfb_cnt_t'(cycle_clocks - 1);

    // Whole register image of the block
    typedef struct packed {
        // Data input synchroniser, two stages
        bfb_pkg::bfb_vec_t s1;
        bfb_pkg::bfb_vec_t s2;
        // Connection mask synchroniser, two stages
        bfb_pkg::bfb_vec_t used1;
        bfb_pkg::bfb_vec_t used2;
        // Inversion mask synchroniser, two stages
        bfb_pkg::bfb_vec_t inv1;
        bfb_pkg::bfb_vec_t inv2;
        // Three-input mode synchroniser, two stages
        logic leg1;
        logic leg2;
        // Program cycle divider and its enable pulse
        bfb_pkg::bfb_cnt_t div;
        logic cyc;
        // Edge history of the previous evaluation
        logic prev_all;
        logic prev_none;
        // Registered block results
        logic and_o;
        logic eand_o;
        logic nand_o;
        logic enand_o;
    } bfb_state_s;

    // Current and next register image
    bfb_state_s st_reg;
    bfb_state_s st_next;

    // Conditioned inputs and shared evaluation terms
    bfb_pkg::bfb_vec_t cond;
    logic all_now;
    logic last_count;

    // Per-block results of the current evaluation
    logic and_now;
    logic nand_now;
    logic eand_now;
    logic enand_now;

    // AND reduction shared by all four blocks
    function automatic logic all_ones(input bfb_pkg::bfb_vec_t v);
        all_ones = &v;
    endfunction

    // Rising edge of a block result against the previous evaluation
    function automatic logic rose_since(input logic now_v, input logic before_v);
        rose_since = now_v && !before_v;
    endfunction

    // Edge pulse, blocked while the block pulsed in the previous cycle
    function automatic logic edge_pulse(input logic now_v, input logic before_v, input logic pulsed_v);
        edge_pulse = rose_since(now_v, before_v) && !pulsed_v;
    endfunction

    // Input conditioning on the synchronised copies
    bfb_cond u_cond (
        .raw_i(st_reg.s2),
        .used_i(st_reg.used2),
        .inv_i(st_reg.inv2),
        .legacy_i(st_reg.leg2),
        .cond_o(cond)
    );

    // Shared reduction and end of the divider count
    assign all_now = all_ones(cond);
    assign last_count = (st_reg.div == div_last);

    // Level results
    assign and_now = all_now;
    assign nand_now = !all_now;

    // Edge AND on the rise of AND, edge NAND on the rise of NAND
    assign eand_now = edge_pulse(and_now, st_reg.prev_all, st_reg.eand_o);
    assign enand_now = edge_pulse(nand_now, st_reg.prev_none, st_reg.enand_o);

    // Next state: synchronisers, cycle divider and evaluation
    always_comb begin
        st_next = st_reg;

        // Two-stage synchronisers; only the second stage reaches logic
        st_next.s1 = IN_I;
        st_next.s2 = st_reg.s1;
        st_next.used1 = USED_I;
        st_next.used2 = st_reg.used1;
        st_next.inv1 = INVERT_I;
        st_next.inv2 = st_reg.inv1;
        st_next.leg1 = LEGACY_I;
        st_next.leg2 = st_reg.leg1;

        // Divider; the enable stands one clock per program cycle
        st_next.cyc = 1'b0;
        if (last_count) begin
            st_next.div = '0;
            st_next.cyc = 1'b1;
        end else begin
            st_next.div = st_reg.div + 8'h01;
        end

        // Evaluation on the enable only; results stand a whole program cycle
        if (st_reg.cyc) begin
            st_next.and_o = and_now;
            st_next.nand_o = nand_now;
            st_next.eand_o = eand_now;
            st_next.enand_o = enand_now;
            st_next.prev_all = and_now;
            st_next.prev_none = nand_now;
        end
    end

    // Register image; reset makes the history look settled
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            // Synchronisers empty
            st_reg.s1 <= '0;
            st_reg.s2 <= '0;
            st_reg.used1 <= '0;
            st_reg.used2 <= '0;
            st_reg.inv1 <= '0;
            st_reg.inv2 <= '0;
            st_reg.leg1 <= 1'b0;
            st_reg.leg2 <= 1'b0;

            // Divider restarts a full program cycle
            st_reg.div <= '0;
            st_reg.cyc <= 1'b0;

            // History reads settled, so no edge fires first
            st_reg.prev_all <= 1'b1;
            st_reg.prev_none <= 1'b1;

            // Results at their idle levels
            st_reg.and_o <= `BFB_OUT_RESET;
            st_reg.eand_o <= `BFB_OUT_RESET;
            st_reg.nand_o <= `BFB_NAND_RESET;
            st_reg.enand_o <= `BFB_OUT_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Level outputs straight from flip-flops; no inversion on output side
    assign AND_O = st_reg.and_o;
    assign NAND_O = st_reg.nand_o;
    // Edge outputs
    assign EDGE_AND_O = st_reg.eand_o;
    assign EDGE_NAND_O = st_reg.enand_o;
    // Evaluation marker
    assign CYCLE_O = st_reg.cyc;
endmodule
`default_nettype wire

// File: testbench/bfb_chk.sv
// Purpose: Port assertions for bfb_top
// Assumes: 20 clocks per program cycle
// Notes: Bound after the module
`timescale 1ns/100ps
`default_nettype none
module bfb_chk (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic AND_O,
    input wire logic EDGE_AND_O,
    input wire logic NAND_O,
    input wire logic EDGE_NAND_O,
    input wire logic CYCLE_O
);
    // One clock for all checks
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    chk_and_nand_pair: assert property (AND_O != NAND_O) else $error("AND equals NAND");
    chk_eand_rise: assert property ($rose(EDGE_AND_O) |-> $rose(AND_O)) else $error("edge AND no rise");
    chk_eand_gap: assert property ($rose(EDGE_AND_O) |-> ##20 !EDGE_AND_O ##19 !EDGE_AND_O)
        else $error("edge AND gap");
    chk_enand_rise: assert property ($rose(EDGE_NAND_O) |-> $rose(NAND_O)) else $error("edge NAND no rise");
    chk_enand_gap: assert property ($rose(EDGE_NAND_O) |-> ##20 !EDGE_NAND_O ##19 !EDGE_NAND_O)
        else $error("edge NAND gap");
    chk_out_moment: assert property ($changed({AND_O, EDGE_AND_O, NAND_O, EDGE_NAND_O}) |-> $fell(CYCLE_O))
        else $error("output moved off evaluation");
    chk_cycle_pulse: assert property (CYCLE_O |=> !CYCLE_O) else $error("cycle pulse too long");
    chk_cycle_period: assert property (CYCLE_O |-> ##20 CYCLE_O) else $error("cycle period wrong");
endmodule
bind bfb_top bfb_chk u_chk (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .AND_O(AND_O), .EDGE_AND_O(EDGE_AND_O),
    .NAND_O(NAND_O), .EDGE_NAND_O(EDGE_NAND_O), .CYCLE_O(CYCLE_O));
`default_nettype wire

// File: testbench/tb_boolean_function_blocks.sv
// Purpose: Self-checking bench for bfb_top
// Assumes: Inputs change just after an evaluation
// Notes: Model compared at every evaluation
`timescale 1ns/100ps
`default_nettype none
module tb_boolean_function_blocks;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic leg = 1'b0;
    logic a_o, ea_o, n_o, en_o, cy_o, a, pa, first;
    logic [3:0] in_v = 4'h0, used_v = 4'hF, inv_v = 4'h0, c;
    int failures = 0, checks = 0, seed = 78923, ticks = 0;
    bfb_top dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .IN_I(in_v), .USED_I(used_v), .INVERT_I(inv_v),
        .LEGACY_I(leg), .AND_O(a_o), .EDGE_AND_O(ea_o), .NAND_O(n_o), .EDGE_NAND_O(en_o), .CYCLE_O(cy_o));
    // Clock and hang guard
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        ticks <= ticks + 1;
        if (ticks == 5000) begin
            failures = failures + 1;
            stop_test();
        end
    end
    // Compare one value
    task automatic check(input string name, input logic seen, input logic exp);
        checks = checks + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("MISMATCH %s exp %b seen %b", name, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Wait for an evaluation, then model and compare
    task automatic eval_cmp();
        int k;
        k = 0;
        while (cy_o !== 1'b1 && k < 40) begin
            @(negedge clk);
            k++;
        end
        @(negedge clk);
        check("cycle_gap", k == (first ? 20 : 19), 1'b1);
        check("cycle_pulse", cy_o, 1'b0);
        c = (in_v ^ inv_v) | ~used_v | {leg, 3'h0};
        a = &c;
        check("and", a_o, a);
        check("nand", n_o, !a);
        check("edge_and", ea_o, a & !pa & !first);
        check("edge_nand", en_o, !a & pa & !first);
        pa = a;
        first = 1'b0;
    endtask
    // Reset, then random inputs once per program cycle
    initial begin
        first = 1'b1;
        pa = 1'b0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 150; i++) begin
            eval_cmp();
            if (i == 75) begin
                rst_n = 1'b0;
                @(negedge clk);
                check("rst_and", a_o, 1'b0);
                check("rst_nand", n_o, 1'b1);
                check("rst_edges", ea_o | en_o | cy_o, 1'b0);
                @(negedge clk);
                rst_n = 1'b1;
                first = 1'b1;
            end
            in_v = 4'($random(seed));
            used_v = 4'($random(seed) | $random(seed));
            inv_v = 4'($random(seed));
            leg = (i % 16) > 11;
        end
        stop_test();
    end
endmodule
`default_nettype wire
